/* hdl/apic_pkg.sv */
package apic_pkg;

    // register indices on the serial control port
    localparam logic [7:0] ADDR_PIN_SELECT   = 8'h15;
    localparam logic [7:0] ADDR_POLARITY     = 8'h16;
    localparam logic [7:0] ADDR_LOS_MASK     = 8'h17;
    localparam logic [7:0] ADDR_FOS_LOL_MASK = 8'h18;
    localparam logic [7:0] ADDR_HS_DIVIDER   = 8'h19;

    // reset values; reserved bits keep these bits forever
    localparam logic [7:0] RST_PIN_SELECT   = 8'hff;
    localparam logic [7:0] RST_POLARITY     = 8'hdf;
    localparam logic [7:0] RST_LOS_MASK     = 8'h07;
    localparam logic [7:0] RST_FOS_LOL_MASK = 8'h3f;
    localparam logic [7:0] RST_HS_DIVIDER   = 8'h20;

    // writable bits of each register
    localparam logic [7:0] WMASK_PIN_SELECT   = 8'h03;
    localparam logic [7:0] WMASK_POLARITY     = 8'h0f;
    localparam logic [7:0] WMASK_LOS_MASK     = 8'h07;
    localparam logic [7:0] WMASK_FOS_LOL_MASK = 8'h07;
    localparam logic [7:0] WMASK_HS_DIVIDER   = 8'he0;

    // field positions
    localparam int BIT_ACTIVE_REFLECT = 1;
    localparam int BIT_PIN_SOURCE     = 0;
    localparam int BIT_ACTIVE_POL     = 3;
    localparam int BIT_BAD_POL        = 2;
    localparam int BIT_LOCK_POL       = 1;
    localparam int BIT_IRQ_POL        = 0;
    localparam int BIT_IN2_MASK       = 2;
    localparam int BIT_IN1_MASK       = 1;
    localparam int BIT_REF_MASK       = 0;
    localparam int BIT_LOCK_MASK      = 0;
    localparam int HS_DIV_LSB         = 5;
    localparam int HS_DIV_MSB         = 7;

    // high-speed divide ratio is code plus this offset
    localparam logic [3:0] HS_DIV_OFFSET = 4'h4;

    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // alarm flags kept by the detectors outside this block
    typedef struct packed {
        logic lock_loss_flag;
        logic input2_freq_offset_flag;
        logic input1_freq_offset_flag;
        logic input2_signal_loss_flag;
        logic input1_signal_loss_flag;
        logic reference_signal_loss_flag;
    } apic_flags_t;

    // one tristate-capable output pin
    typedef struct packed {
        logic value;
        logic oe;
    } apic_pin_t;

endpackage : apic_pkg

/* hdl/apic_top.sv */
// Overview of operation
// [RL1] reflect enable low tristates shared pin; high drives clock-active status on it
// [RL2] reflect enable counts only when the pin is not the clock selector
// [RL3] pin-select low uses register field; high lets the shared pin select
// [RL4] pin-select is honoured only under manual selection, else disregarded
// [RL5] clock-active polarity bit: 0 active low, 1 active high
// [RL6] clock-bad polarity bit sets both clock-bad outputs: 0 low, 1 high
// [RL7] lock-loss polarity bit: 0 active low, 1 active high
// [RL8] interrupt polarity bit on shared interrupt pin: 0 low, 1 high
// [RL9] signal-loss mask zero lets its flag interrupt; one excludes it
// [RL10] mask writes never alter the alarm flags themselves
// [RL11] offset and lock-loss mask zero lets flag interrupt; one excludes it
// [RL12] high-speed divide ratio equals the 3-bit code plus four
// [RL13] pin-select register resets to all ones
// [RL14] polarity register resets to 0xdf, all outputs active high
// [RL15] offset and lock-loss mask register resets to 0x3f
// [RL16] divider register resets to 0x20, ratio five
// [RL17] interrupt pin disabled hides interrupt; tristate unless input1 bad reflected
// [RL18] lock-loss pin enable drives the lock-loss pin, else tristate
// [RL19] interrupt is the OR of all unmasked flags before polarity
// [RL20] reserved bits are read-only and ignore writes
module apic_top (
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic [7:0]           reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output logic      [7:0]           reg_rdata_o,
    input  wire logic                 clock_active_status_i,
    input  wire logic                 input1_bad_i,
    input  wire logic                 input2_bad_i,
    input  wire logic                 lock_loss_status_i,
    input  wire apic_pkg::apic_flags_t flags_i,
    input  wire logic                 manual_select_i,
    input  wire logic [1:0]           clock_select_field_i,
    input  wire logic                 interrupt_pin_en_i,
    input  wire logic                 input1_bad_reflect_en_i,
    input  wire logic                 input2_bad_reflect_en_i,
    input  wire logic                 lock_loss_pin_enable_i,
    input  wire logic                 select_active_shared_pin_i,
    output logic                      select_active_shared_pin_o,
    output logic                      select_active_shared_pin_oe_o,
    output logic                      interrupt_clkbad_shared_pin_o,
    output logic                      interrupt_clkbad_shared_pin_oe_o,
    output logic                      input2_bad_pin_o,
    output logic                      input2_bad_pin_oe_o,
    output logic                      lock_loss_pin_o,
    output logic                      lock_loss_pin_oe_o,
    output logic      [1:0]           clock_select_o,
    output logic                      pin_selects_clock_o,
    output logic      [3:0]           hs_divide_ratio_o,
    output logic                      irq_raw_o
);

    // a status is shown active high when pol is 1, inverted otherwise
    function automatic logic apply_pol(input logic status, input logic pol);
        apply_pol = pol ? status : ~status;
    endfunction : apply_pol

    // writable bits take new data, reserved bits keep their reset value
    function automatic logic [7:0] merge_write(input logic [7:0] old_v,
                                               input logic [7:0] new_v,
                                               input logic [7:0] wmask);
        merge_write = (old_v & ~wmask) | (new_v & wmask);
    endfunction : merge_write

    logic [7:0] pin_select_q;
    logic [7:0] polarity_q;
    logic [7:0] los_mask_q;
    logic [7:0] fos_lol_mask_q;
    logic [7:0] hs_divider_q;

    logic [7:0]        rdata_d;
    logic [5:0]        mask_vec;
    logic              irq_any;
    logic              pin_controls_sel;
    logic              active_drive;
    apic_pkg::apic_pin_t sel_pin_d;
    apic_pkg::apic_pin_t int_pin_d;
    apic_pkg::apic_pin_t c2b_pin_d;
    apic_pkg::apic_pin_t lock_loss_pin_enable_d;
    logic [1:0]        clock_select_d;
    logic [3:0]        hs_ratio_d;

    // pin select / reflect register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pin_select_q <= apic_pkg::RST_PIN_SELECT; // see [RL13]
        end else if (ce_i && reg_wr_i && reg_addr_i == apic_pkg::ADDR_PIN_SELECT) begin
            pin_select_q <= merge_write(pin_select_q, reg_wdata_i,
                                        apic_pkg::WMASK_PIN_SELECT); // see [RL20]
        end
    end

    // polarity register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            polarity_q <= apic_pkg::RST_POLARITY; // see [RL14]
        end else if (ce_i && reg_wr_i && reg_addr_i == apic_pkg::ADDR_POLARITY) begin
            polarity_q <= merge_write(polarity_q, reg_wdata_i,
                                      apic_pkg::WMASK_POLARITY); // see [RL20]
        end
    end

    // mask registers; flags live outside and are never touched here
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            los_mask_q     <= apic_pkg::RST_LOS_MASK;
            fos_lol_mask_q <= apic_pkg::RST_FOS_LOL_MASK; // see [RL15]
        end else if (ce_i && reg_wr_i) begin
            if (reg_addr_i == apic_pkg::ADDR_LOS_MASK) begin
                los_mask_q <= merge_write(los_mask_q, reg_wdata_i,
                                          apic_pkg::WMASK_LOS_MASK); // see [RL10]
            end
            if (reg_addr_i == apic_pkg::ADDR_FOS_LOL_MASK) begin
                fos_lol_mask_q <= merge_write(fos_lol_mask_q, reg_wdata_i,
                                              apic_pkg::WMASK_FOS_LOL_MASK); // see [RL10]
            end
        end
    end

    // high-speed divider register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            hs_divider_q <= apic_pkg::RST_HS_DIVIDER; // see [RL16]
        end else if (ce_i && reg_wr_i && reg_addr_i == apic_pkg::ADDR_HS_DIVIDER) begin
            hs_divider_q <= merge_write(hs_divider_q, reg_wdata_i,
                                        apic_pkg::WMASK_HS_DIVIDER); // see [RL20]
        end
    end

    // read mux; unmapped indices read zero rather than float
    always_comb begin
        case (reg_addr_i)
            apic_pkg::ADDR_PIN_SELECT:   rdata_d = pin_select_q;
            apic_pkg::ADDR_POLARITY:     rdata_d = polarity_q;
            apic_pkg::ADDR_LOS_MASK:     rdata_d = los_mask_q;
            apic_pkg::ADDR_FOS_LOL_MASK: rdata_d = fos_lol_mask_q;
            apic_pkg::ADDR_HS_DIVIDER:   rdata_d = hs_divider_q;
            default:                     rdata_d = apic_pkg::READ_UNMAPPED;
        endcase
    end

    // read data is held until the next read strobe
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            reg_rdata_o <= apic_pkg::READ_UNMAPPED;
        end else if (ce_i && reg_rd_i) begin
            reg_rdata_o <= rdata_d;
        end
    end

    // mask vector laid out in the same order as the flag struct
    assign mask_vec = {fos_lol_mask_q[apic_pkg::BIT_LOCK_MASK],
                       fos_lol_mask_q[apic_pkg::BIT_IN2_MASK],
                       fos_lol_mask_q[apic_pkg::BIT_IN1_MASK],
                       los_mask_q[apic_pkg::BIT_IN2_MASK],
                       los_mask_q[apic_pkg::BIT_IN1_MASK],
                       los_mask_q[apic_pkg::BIT_REF_MASK]};

    // a set mask bit removes its flag from the OR
    assign irq_any = |(flags_i & ~mask_vec); // see [RL9] see [RL11] see [RL19]

    // the pin is an input only when manual mode hands it selection
    assign pin_controls_sel = manual_select_i
                            & pin_select_q[apic_pkg::BIT_PIN_SOURCE]; // see [RL4]
    assign active_drive = pin_select_q[apic_pkg::BIT_ACTIVE_REFLECT]
                        & ~pin_controls_sel; // see [RL1] see [RL2]

    // clock select source; in automatic mode the field is passed on untouched
    always_comb begin
        if (pin_controls_sel) begin
            clock_select_d = {1'b0, select_active_shared_pin_i}; // see [RL3]
        end else begin
            clock_select_d = clock_select_field_i; // see [RL3]
        end
    end

    assign hs_ratio_d = {1'b0, hs_divider_q[apic_pkg::HS_DIV_MSB:apic_pkg::HS_DIV_LSB]}
                      + apic_pkg::HS_DIV_OFFSET; // see [RL12]

    // shared select / active pin
    always_comb begin
        sel_pin_d.oe    = active_drive; // see [RL1]
        sel_pin_d.value = active_drive
                        & apply_pol(clock_active_status_i,
                                    polarity_q[apic_pkg::BIT_ACTIVE_POL]); // see [RL5]
    end

    // interrupt wins the shared pin; else input1 bad; else released
    always_comb begin
        int_pin_d.oe    = 1'b0;
        int_pin_d.value = 1'b0;
        if (interrupt_pin_en_i) begin
            int_pin_d.oe    = 1'b1;
            int_pin_d.value = apply_pol(irq_any,
                                        polarity_q[apic_pkg::BIT_IRQ_POL]); // see [RL8]
        end else if (input1_bad_reflect_en_i) begin
            int_pin_d.oe    = 1'b1; // see [RL17]
            int_pin_d.value = apply_pol(input1_bad_i,
                                        polarity_q[apic_pkg::BIT_BAD_POL]); // see [RL6]
        end
    end

    // input2 bad pin and lock-loss pin
    always_comb begin
        c2b_pin_d.oe    = input2_bad_reflect_en_i;
        c2b_pin_d.value = input2_bad_reflect_en_i
                        & apply_pol(input2_bad_i,
                                    polarity_q[apic_pkg::BIT_BAD_POL]); // see [RL6]
        lock_loss_pin_enable_d.oe    = lock_loss_pin_enable_i; // see [RL18]
        lock_loss_pin_enable_d.value = lock_loss_pin_enable_i
                        & apply_pol(lock_loss_status_i,
                                    polarity_q[apic_pkg::BIT_LOCK_POL]); // see [RL7]
    end

    // pin outputs registered: one cycle latency, but no glitches on the board
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            select_active_shared_pin_o       <= 1'b0;
            select_active_shared_pin_oe_o    <= 1'b0;
            interrupt_clkbad_shared_pin_o    <= 1'b0;
            interrupt_clkbad_shared_pin_oe_o <= 1'b0;
            input2_bad_pin_o                 <= 1'b0;
            input2_bad_pin_oe_o              <= 1'b0;
            lock_loss_pin_o                  <= 1'b0;
            lock_loss_pin_oe_o               <= 1'b0;
        end else if (ce_i) begin
            select_active_shared_pin_o       <= sel_pin_d.value;
            select_active_shared_pin_oe_o    <= sel_pin_d.oe;
            interrupt_clkbad_shared_pin_o    <= int_pin_d.value;
            interrupt_clkbad_shared_pin_oe_o <= int_pin_d.oe;
            input2_bad_pin_o                 <= c2b_pin_d.value;
            input2_bad_pin_oe_o              <= c2b_pin_d.oe;
            lock_loss_pin_o                  <= lock_loss_pin_enable_d.value;
            lock_loss_pin_oe_o               <= lock_loss_pin_enable_d.oe;
        end
    end

    // selection and divider results to the clock path
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            clock_select_o      <= 2'h0;
            pin_selects_clock_o <= 1'b0;
            hs_divide_ratio_o   <= 4'h0;
            irq_raw_o           <= 1'b0;
        end else if (ce_i) begin
            clock_select_o      <= clock_select_d;
            pin_selects_clock_o <= pin_controls_sel;
            hs_divide_ratio_o   <= hs_ratio_d;
            irq_raw_o           <= irq_any;
        end
    end

endmodule : apic_top

/* tb/apic_assertions.sv */
// protocol and pin checks seen from the top-level ports only
module apic_chk (
    input wire logic                  clk_sys_i,
    input wire logic                  rst_i,
    input wire logic                  ce_i,
    input wire logic [7:0]            reg_addr_i,
    input wire logic [7:0]            reg_wdata_i,
    input wire logic                  reg_wr_i,
    input wire logic                  reg_rd_i,
    input wire logic [7:0]            reg_rdata_o,
    input wire apic_pkg::apic_flags_t flags_i,
    input wire logic                  manual_select_i,
    input wire logic [1:0]            clock_select_field_i,
    input wire logic                  interrupt_pin_en_i,
    input wire logic                  input1_bad_reflect_en_i,
    input wire logic                  input2_bad_reflect_en_i,
    input wire logic                  lock_loss_pin_enable_i,
    input wire logic                  select_active_shared_pin_o,
    input wire logic                  select_active_shared_pin_oe_o,
    input wire logic                  interrupt_clkbad_shared_pin_oe_o,
    input wire logic                  input2_bad_pin_oe_o,
    input wire logic                  lock_loss_pin_oe_o,
    input wire logic [1:0]            clock_select_o,
    input wire logic [3:0]            hs_divide_ratio_o,
    input wire logic                  irq_raw_o
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    a_unmapped_read: assert property (ce_i && reg_rd_i && !(reg_addr_i inside {[8'h15:8'h19]})
        |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    a_reserved_read: assert property (ce_i && reg_rd_i && reg_addr_i == 8'h15
        |=> reg_rdata_o[7:2] == 6'h3f) else $error("reserved bits lost");
    // second cycle must not rewrite the divider, else the figure is ambiguous
    a_ratio_code: assert property (ce_i && reg_wr_i && reg_addr_i == 8'h19 ##1
        (ce_i && !(reg_wr_i && reg_addr_i == 8'h19))
        |=> hs_divide_ratio_o == {1'b0, $past(reg_wdata_i[7:5], 2)} + 4'h4)
        else $error("divide ratio wrong");
    a_lock_loss_pin_enable_enable: assert property ($past(ce_i) && !$past(rst_i)
        |-> lock_loss_pin_oe_o == $past(lock_loss_pin_enable_i)) else $error("lol oe wrong");
    a_c2b_pin_enable: assert property ($past(ce_i) && !$past(rst_i)
        |-> input2_bad_pin_oe_o == $past(input2_bad_reflect_en_i)) else $error("c2b oe wrong");
    a_int_pin_enable: assert property ($past(ce_i) && !$past(rst_i)
        |-> interrupt_clkbad_shared_pin_oe_o
            == $past(interrupt_pin_en_i | input1_bad_reflect_en_i)) else $error("int oe wrong");
    a_irq_no_flags: assert property ($past(ce_i) && !$past(rst_i) && $past(flags_i) == 6'h00
        |-> !irq_raw_o) else $error("irq without flag");
    a_auto_select: assert property ($past(ce_i) && !$past(rst_i) && !$past(manual_select_i)
        |-> clock_select_o == $past(clock_select_field_i)) else $error("auto select wrong");
    a_tristate_low: assert property (!select_active_shared_pin_oe_o
        |-> !select_active_shared_pin_o) else $error("released pin driven");
    a_ce_freeze: assert property (!$past(ce_i) && !$past(rst_i)
        |-> $stable(reg_rdata_o) && $stable(irq_raw_o) && $stable(clock_select_o))
        else $error("outputs moved with clock enable low");
    a_reset_clear: assert property ($past(rst_i) |-> reg_rdata_o == 8'h00 && !irq_raw_o
        && hs_divide_ratio_o == 4'h0) else $error("outputs not cleared by reset");
endmodule : apic_chk

bind apic_top apic_chk i_chk (.*);

/* tb/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_sys_i, rst_i, ce_i, reg_wr_i, reg_rd_i, manual_select_i;
    logic clock_active_status_i, input1_bad_i, input2_bad_i, lock_loss_status_i;
    logic interrupt_pin_en_i, input1_bad_reflect_en_i, input2_bad_reflect_en_i;
    logic lock_loss_pin_enable_i, select_active_shared_pin_i, irq_raw_o, pin_selects_clock_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, sv;
    logic [1:0] clock_select_field_i, clock_select_o;
    logic [3:0] hs_divide_ratio_o;
    logic select_active_shared_pin_o, select_active_shared_pin_oe_o, input2_bad_pin_o;
    logic interrupt_clkbad_shared_pin_o, interrupt_clkbad_shared_pin_oe_o, input2_bad_pin_oe_o;
    logic lock_loss_pin_o, lock_loss_pin_oe_o;
    apic_pkg::apic_flags_t flags_i;
    logic [7:0] sh [5];
    int n_fail, total_checks, k;
    // reset values and writable bits, same order as the register indices
    localparam logic [7:0] RV [5] = '{8'hff, 8'hdf, 8'h07, 8'h3f, 8'h20};
    localparam logic [7:0] WM [5] = '{8'h03, 8'h0f, 8'h07, 8'h07, 8'he0};

    apic_top i_dut (.*);

    // free-running system clock
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [7:0] rd_exp(input logic [7:0] a);
        return (a >= 8'h15 && a <= 8'h19) ? sh[a - 8'h15] : 8'h00;
    endfunction : rd_exp

    // pin outputs worked out from the shadow registers and live inputs
    function automatic logic [15:0] pin_exp();
        logic src, irq, so;
        src = manual_select_i & sh[0][0];
        so = sh[0][1] & ~src;
        irq = |(flags_i & ~{sh[3][0], sh[3][2], sh[3][1], sh[2][2:0]});
        return {4'h0, so, so & ~(clock_active_status_i ^ sh[1][3]),
                interrupt_pin_en_i | input1_bad_reflect_en_i,
                interrupt_pin_en_i ? ~(irq ^ sh[1][0])
                    : input1_bad_reflect_en_i & ~(input1_bad_i ^ sh[1][2]),
                input2_bad_reflect_en_i, input2_bad_reflect_en_i & ~(input2_bad_i ^ sh[1][2]),
                lock_loss_pin_enable_i, lock_loss_pin_enable_i & ~(lock_loss_status_i ^ sh[1][1]),
                irq, src, src ? {1'b0, select_active_shared_pin_i} : clock_select_field_i};
    endfunction : pin_exp

    // the bus tasks wr and rd start and end 10 ns after a rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(posedge clk_sys_i);
        #10;
        reg_wr_i = 1'b0;
        if (a >= 8'h15 && a <= 8'h19) sh[a - 8'h15] = (RV[a - 8'h15] & ~WM[a - 8'h15]) | (d & WM[a - 8'h15]);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(posedge clk_sys_i);
        #10;
        reg_rd_i = 1'b0;
        chk({8'h00, reg_rdata_o}, {8'h00, exp});
    endtask : rd

    task automatic rnd_in();
        {clock_active_status_i, input1_bad_i, input2_bad_i, lock_loss_status_i} = 4'($urandom);
        {interrupt_pin_en_i, input1_bad_reflect_en_i, input2_bad_reflect_en_i} = 3'($urandom);
        {lock_loss_pin_enable_i, select_active_shared_pin_i, manual_select_i} = 3'($urandom);
        clock_select_field_i = 2'($urandom);
        flags_i = 6'($urandom);
    endtask : rnd_in

    // hang guard, far beyond the expected run of about 470 cycles
    initial begin
        #2000000;
        n_fail++;
        test_done();
    end

    initial begin
        k = $urandom(54019);
        {rst_i, ce_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {2'b11, 18'h0};
        rnd_in();
        repeat (3) @(posedge clk_sys_i);
        #10;
        rst_i = 1'b0;
        for (k = 0; k < 5; k++) rd(8'h15 + 8'(k), RV[k]);
        sh = RV;
        // zeros, ones, then random data, unmapped neighbours included
        for (k = 0; k < 21; k++) begin
            wr(8'h14 + 8'(k % 7), k < 7 ? 8'h00 : k < 14 ? 8'hff : 8'($urandom));
            rd(8'h14 + 8'(k % 7), rd_exp(8'h14 + 8'(k % 7)));
        end
        for (k = 0; k < 8; k++) begin
            wr(8'h19, {3'(k), 5'h1f});
            @(posedge clk_sys_i);
            #10;
            chk({12'h0, hs_divide_ratio_o}, {12'h0, 4'(k) + 4'h4});
        end
        wr(8'h17, 8'h00);
        wr(8'h18, 8'h00);
        // single-flag corners first, then random settings
        for (k = 0; k < 300; k++) begin
            if (k > 5 && k % 3 == 0) wr(8'h15 + 8'($urandom_range(3)), 8'($urandom));
            rnd_in();
            if (k < 6) flags_i = 6'h01 << k;
            @(posedge clk_sys_i);
            #10;
            chk({select_active_shared_pin_oe_o, select_active_shared_pin_o,
                 interrupt_clkbad_shared_pin_oe_o, interrupt_clkbad_shared_pin_o,
                 input2_bad_pin_oe_o, input2_bad_pin_o, lock_loss_pin_oe_o,
                 lock_loss_pin_o, irq_raw_o, pin_selects_clock_o, clock_select_o},
                pin_exp());
        end
        // clock enable low must swallow a write
        sv = sh[4];
        ce_i = 1'b0;
        wr(8'h19, 8'h00);
        rnd_in();
        @(posedge clk_sys_i);
        #10;
        ce_i = 1'b1;
        sh[4] = sv;
        rd(8'h19, sv);
        test_done();
    end
endmodule : tb
